/* hw/tsf_top.sv */
// serial status frame and driver control of the triple half-bridge
// assumes mode-0 style master: sample on rising, shift on falling sclk
`timescale 1ns/1ps
module tsf_top (
	input  wire logic                          core_clk,
	input  wire logic                          rst,
	input  wire logic                          clk_en,
	input  wire logic                          chip_select_bar,
	input  wire logic                          sclk,
	input  wire logic                          sdi,
	input  wire logic [tsf_pkg::NUM_PAIRS-1:0] warn_level,
	input  wire logic [tsf_pkg::NUM_PAIRS-1:0] shut_level,
	input  wire logic                          supply_lockout,
	output logic                               sdo,
	output logic                               sdo_oe,
	output logic [tsf_pkg::NUM_PAIRS-1:0]      high_side_switch,
	output logic [tsf_pkg::NUM_PAIRS-1:0]      low_side_switch,
	output logic                               thermal_warning_flag,
	output logic                               shutdown_latched
);
	import tsf_pkg::*;

	// ****************************************
	// pin stage and thermal latches
	// ****************************************
	tsf_link_if lnk ();

	logic [NUM_PAIRS-1:0] warn_s1_r, warn_s2_r, shut_s1_r, shut_s2_r;
	logic                 lock_s1_r, lock_s2_r;
	logic                 warn_w, sd_w, clr_w, on_w;

	tsf_pin_sync u_pins (
		.core_clk        (core_clk),
		.rst             (rst),
		.clk_en          (clk_en),
		.chip_select_bar (chip_select_bar),
		.sclk            (sclk),
		.sdi             (sdi),
		.lnk             (lnk)
	);

	always_ff @(posedge core_clk) begin
		if (rst) begin
			warn_s1_r <= '0;
			warn_s2_r <= '0;
			shut_s1_r <= '0;
			shut_s2_r <= '0;
			lock_s1_r <= 1'b1;
			lock_s2_r <= 1'b1;
		end else if (clk_en) begin
			warn_s1_r <= warn_level;
			warn_s2_r <= warn_s1_r;
			shut_s1_r <= shut_level;
			shut_s2_r <= shut_s1_r;
			lock_s1_r <= supply_lockout;
			lock_s2_r <= lock_s1_r;
		end
	end

	tsf_thermal u_therm (
		.core_clk             (core_clk),
		.rst                  (rst),
		.clk_en               (clk_en),
		.warn_level           (warn_s2_r),
		.shut_level           (shut_s2_r),
		.clear_req            (clr_w),
		.turn_on_cmd          (on_w),
		.thermal_warning_flag (warn_w),
		.shutdown_latched     (sd_w)
	);

	// ****************************************
	// frame shifter
	// ****************************************
	function automatic logic [WORD_W-1:0] status_word(input logic warn);
		logic [WORD_W-1:0] w;
		w = '0;
		w[WARN_BIT] = warn;
		return w;
	endfunction

	// status goes out bit 0 first, so the warning is on the pin before any sclk
	function automatic logic [WORD_W-1:0] wire_order(input logic [WORD_W-1:0] w);
		logic [WORD_W-1:0] r;
		r = '0;
		for (int i = 0; i < WORD_W; i++) begin
			r[i] = w[WORD_W-1-i];
		end
		return r;
	endfunction

	function automatic logic drives_any(input logic [WORD_W-1:0] c);
		return |c[DRV_HI:DRV_LO];
	endfunction

	typedef enum logic [2:0] {
		TSF_IDLE  = 3'b001,
		TSF_SHIFT = 3'b010,
		TSF_APPLY = 3'b100
	} tsf_state_e;

	typedef struct packed {
		tsf_state_e        fsm;
		logic [WORD_W-1:0] shreg;
		logic [WORD_W-1:0] rx;
		logic [CNT_W-1:0]  cnt;
		logic              whole;
		logic              got_word;
		logic [WORD_W-1:0] cmd;
		logic              clr;
		logic              on;
		logic              sdo;
		logic              sdo_oe;
		logic [NUM_PAIRS-1:0] hi_on;
		logic [NUM_PAIRS-1:0] lo_on;
		logic              warn;
		logic              sd;
	} tsf_top_s;

	tsf_top_s st_r;
	tsf_top_s st_nxt;

	always_comb begin
		st_nxt = st_r;
		st_nxt.clr = 1'b0;
		st_nxt.on  = 1'b0;
		case (st_r.fsm)
			TSF_IDLE: begin
				// [R08] warning loaded at fall
				// [R11] status word leads frame
				if (lnk.cs_fall) begin
					st_nxt.shreg = wire_order(status_word(warn_w));
					st_nxt.cnt   = CNT_ZERO;
					st_nxt.whole = 1'b0;
					st_nxt.got_word = 1'b0;
					st_nxt.fsm   = TSF_SHIFT;
				end
			end
			TSF_SHIFT: begin
				// [R15] input only while selected
				if (lnk.clk_rise && lnk.cs_active) begin
					st_nxt.rx    = {st_r.rx[WORD_W-2:0], lnk.sdi};
					st_nxt.cnt   = st_r.cnt + 4'h1;
					st_nxt.whole = (st_r.cnt == CNT_LAST);
					if (st_r.cnt == CNT_LAST) begin
						st_nxt.got_word = 1'b1;
					end
				end
				// [R10] shift only on clock edges
				// [R14] input passes to output
				if (lnk.clk_fall && lnk.cs_active) begin
					st_nxt.shreg = {st_r.shreg[WORD_W-2:0], st_r.rx[0]};
				end
				if (lnk.cs_rise) begin
					st_nxt.fsm = TSF_APPLY;
				end
			end
			TSF_APPLY: begin
				// [R17] whole words only
				// [R13] frame length check
				if (st_r.whole && st_r.got_word) begin
					st_nxt.cmd = st_r.rx;
					// [R07] bit 0 clears status
					st_nxt.clr = st_r.rx[CLEAR_BIT];
					st_nxt.on  = drives_any(st_r.rx);
				end
				st_nxt.fsm = TSF_IDLE;
			end
			default: begin
				st_nxt.fsm = TSF_IDLE;
			end
		endcase
		// [R09] output shows warning first after fall
		st_nxt.sdo    = (st_nxt.fsm == TSF_SHIFT) ? st_nxt.shreg[WORD_W-1] : 1'b0;
		st_nxt.sdo_oe = (st_nxt.fsm == TSF_SHIFT);
		// [R05] shutdown forces all off
		// [R16] off under lockout
		if (sd_w || lock_s2_r) begin
			st_nxt.hi_on = '0;
			st_nxt.lo_on = '0;
		end else begin
			st_nxt.hi_on = {st_r.cmd[6], st_r.cmd[4], st_r.cmd[2]};
			st_nxt.lo_on = {st_r.cmd[5], st_r.cmd[3], st_r.cmd[1]};
		end
		st_nxt.warn = warn_w;
		st_nxt.sd = sd_w;
	end

	assign clr_w = st_r.clr;
	assign on_w  = st_r.on;

	always_ff @(posedge core_clk) begin
		if (rst) begin
			st_r <= '{fsm: TSF_IDLE, shreg: '0, rx: '0, cnt: CNT_ZERO, whole: 1'b0,
				got_word: 1'b0, cmd: CMD_RESET, clr: 1'b0, on: 1'b0, sdo: 1'b0,
				sdo_oe: 1'b0, hi_on: '0, lo_on: '0, warn: 1'b0, sd: 1'b0};
		end else if (clk_en) begin
			st_r <= st_nxt;
		end
	end

	assign sdo                  = st_r.sdo;
	assign sdo_oe               = st_r.sdo_oe;
	assign high_side_switch     = st_r.hi_on;
	assign low_side_switch      = st_r.lo_on;
	assign thermal_warning_flag = st_r.warn;
	assign shutdown_latched     = st_r.sd;
endmodule

/* hw/tsf_pkg.sv */
// package of constants for the thermal status serial frame block
// assumes a 100 MHz core clock sampling the serial pins
//
// What this block does
// [R01] three monitors, each warning and shutdown level
// [R02] warning sets flag, drivers stay on
// [R03] warning flag is status bit 0, latched
// [R04] flag cleared only by status clear request
// [R05] any shutdown latches every driver off
// [R06] shutdown release needs cool, on-command, clear request
// [R07] status clear request is command bit 0
// [R08] chip select fall drives warning onto output
// [R09] output low without warning, high with warning
// [R10] idle clock holds bit; toggling shifts status
// [R11] first sixteen bits out are status word
// [R12] master sends further commands after status words
// [R13] frame holds whole multiples of sixteen bits
// [R14] input bits pass through to serial output
// [R15] input ignored unless own chip select active
// [R16] drivers start off, stay off under lockout
// [R17] apply last word only on whole-word frames
package tsf_pkg;
	localparam int WORD_W       = 16;
	localparam int CNT_W        = 4;
	localparam int NUM_PAIRS    = 3;
	localparam int CLEAR_BIT    = 0;
	localparam int WARN_BIT     = 0;
	localparam int DRV_LO       = 1;
	localparam int DRV_HI       = 6;
	localparam logic [15:0] CMD_RESET = 16'h0000;
	localparam logic [3:0]  CNT_ZERO  = 4'h0;
	localparam logic [3:0]  CNT_LAST  = 4'hf;
endpackage

/* hw/tsf_link_if.sv */
// interface carrying decoded serial events from the pin stage to the core
// assumes both ends run on core_clk
`timescale 1ns/1ps
interface tsf_link_if;
	logic cs_active;
	logic cs_fall;
	logic cs_rise;
	logic clk_rise;
	logic clk_fall;
	logic sdi;
	modport pins (output cs_active, cs_fall, cs_rise, clk_rise, clk_fall, sdi);
	modport core (input cs_active, cs_fall, cs_rise, clk_rise, clk_fall, sdi);
endinterface

/* hw/tsf_pin_sync.sv */
// two-stage synchronisers and edge finders for the serial pins
// assumes pins are asynchronous to core_clk
`timescale 1ns/1ps
module tsf_pin_sync (
	input  wire logic core_clk,
	input  wire logic rst,
	input  wire logic clk_en,
	input  wire logic chip_select_bar,
	input  wire logic sclk,
	input  wire logic sdi,
	tsf_link_if.pins  lnk
);
	import tsf_pkg::*;

	typedef struct packed {
		logic [1:0] cs_s;
		logic [1:0] ck_s;
		logic [1:0] di_s;
		logic       cs_d;
		logic       ck_d;
	} tsf_sync_s;

	tsf_sync_s st_r;
	tsf_sync_s st_nxt;

	always_comb begin
		st_nxt = st_r;
		st_nxt.cs_s = {st_r.cs_s[0], chip_select_bar};
		st_nxt.ck_s = {st_r.ck_s[0], sclk};
		st_nxt.di_s = {st_r.di_s[0], sdi};
		st_nxt.cs_d = st_r.cs_s[1];
		st_nxt.ck_d = st_r.ck_s[1];
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			st_r <= '{cs_s: 2'h3, ck_s: 2'h0, di_s: 2'h0, cs_d: 1'b1, ck_d: 1'b0};
		end else if (clk_en) begin
			st_r <= st_nxt;
		end
	end

	// edges found only from the second stage
	assign lnk.cs_active = ~st_r.cs_s[1];
	assign lnk.cs_fall   = st_r.cs_d & ~st_r.cs_s[1];
	assign lnk.cs_rise   = ~st_r.cs_d & st_r.cs_s[1];
	assign lnk.clk_rise  = ~st_r.ck_d & st_r.ck_s[1];
	assign lnk.clk_fall  = st_r.ck_d & ~st_r.ck_s[1];
	assign lnk.sdi       = st_r.di_s[1];
endmodule

/* hw/tsf_thermal.sv */
// three thermal monitors with latched warning and shutdown
// assumes sensor levels already on core_clk
`timescale 1ns/1ps
module tsf_thermal (
	input  wire logic                        core_clk,
	input  wire logic                        rst,
	input  wire logic                        clk_en,
	input  wire logic [tsf_pkg::NUM_PAIRS-1:0] warn_level,
	input  wire logic [tsf_pkg::NUM_PAIRS-1:0] shut_level,
	input  wire logic                        clear_req,
	input  wire logic                        turn_on_cmd,
	output logic                             thermal_warning_flag,
	output logic                             shutdown_latched
);
	import tsf_pkg::*;

	typedef struct packed {
		logic warn;
		logic sd;
	} tsf_therm_s;

	tsf_therm_s st_r;
	tsf_therm_s st_nxt;

	always_comb begin
		st_nxt = st_r;
		// [R04] clear when cooled
		if (clear_req && !(|warn_level)) begin
			st_nxt.warn = 1'b0;
		end
		// [R02] warning sets flag
		// [R03] set wins over clear
		if (|warn_level) begin
			st_nxt.warn = 1'b1;
		end
		// [R06] release needs cool and on
		if (clear_req && turn_on_cmd && !(|shut_level)) begin
			st_nxt.sd = 1'b0;
		end
		// [R05] any sensor trips all
		// [R01] three independent sensors
		if (|shut_level) begin
			st_nxt.sd = 1'b1;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			st_r <= '0;
		end else if (clk_en) begin
			st_r <= st_nxt;
		end
	end

	assign thermal_warning_flag = st_r.warn;
	assign shutdown_latched     = st_r.sd;
endmodule

/* verif/tsf_top_sva.sv */
// checker on the ports of the thermal status frame block
// assumes one core_clk domain; bound below
`timescale 1ns/1ps
module tsf_top_sva (
	input wire logic       core_clk,
	input wire logic       rst,
	input wire logic       clk_en,
	input wire logic       chip_select_bar,
	input wire logic       sclk,
	input wire logic       sdi,
	input wire logic [2:0] warn_level,
	input wire logic [2:0] shut_level,
	input wire logic       supply_lockout,
	input wire logic       sdo,
	input wire logic       sdo_oe,
	input wire logic [2:0] high_side_switch,
	input wire logic [2:0] low_side_switch,
	input wire logic       thermal_warning_flag,
	input wire logic       shutdown_latched
);
	// ***
	// checks
	// ***
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	sequence s_sel;
		$fell(chip_select_bar) ##1 !chip_select_bar [*6];
	endsequence
	sequence s_idle;
		(!chip_select_bar && !sclk) [*8];
	endsequence
	a_sel_warn: assert property (
		s_sel |-> sdo_oe && sdo == thermal_warning_flag)
		else $error("sdo not warning at select");
	a_idle_hold: assert property (s_idle |=> $stable(sdo))
		else $error("sdo moved with sclk idle");
	a_warn_set: assert property (|warn_level |-> ##[1:5] thermal_warning_flag)
		else $error("warning not latched");
	a_warn_clear: assert property (
		$fell(thermal_warning_flag) |-> chip_select_bar && !warn_level)
		else $error("warning cleared wrongly");
	a_shut_set: assert property (|shut_level |-> ##[1:5] shutdown_latched)
		else $error("shutdown not latched");
	a_shut_off: assert property (
		|shut_level |-> ##6 !high_side_switch && !low_side_switch)
		else $error("driver on in shutdown");
	a_lock_off: assert property (
		supply_lockout [*5] |-> !high_side_switch && !low_side_switch)
		else $error("driver on in lockout");
	a_reset_off: assert property (
		$past(rst) |-> !sdo_oe && !high_side_switch && !low_side_switch)
		else $error("output live after reset");
endmodule

bind tsf_top tsf_top_sva u_sva (.*);

/* verif/tsf_spi_master.sv */
// serial master model on the select, clock and data pins
// assumes the block samples the pins on its core clock
`timescale 1ns/1ps
module tsf_spi_master (
	output logic      chip_select_bar,
	output logic      sclk,
	output logic      sdi,
	input  wire logic sdo
);
	// ***
	// frame driver
	// ***
	logic        first;
	logic [31:0] rx;
	event        done;
	initial begin
		chip_select_bar = 1'b1;
		sclk = 1'b0;
		sdi = 1'b0;
	end
	task automatic xfer(input int n, input logic [31:0] tx);
		chip_select_bar = 1'b0;
		#120 first = sdo;
		for (int i = n - 1; i >= 0; i--) begin
			sdi = tx[i];
			#40 sclk = 1'b1;
			rx = {rx[30:0], sdo};
			#40 sclk = 1'b0;
		end
		#120 chip_select_bar = 1'b1;
		// the master drives the data line low after select rises
		sdi = 1'b0;
		#200 ->done;
	endtask
endmodule

/* verif/tb_top.sv */
// bench for the thermal status frame block
// assumes the serial master model and the bound checker
`timescale 1ns/1ps
module tb_top;
	import tsf_pkg::*;
	logic        core_clk, rst, clk_en, supply_lockout, chip_select_bar, sclk, sdi;
	logic        sdo, sdo_oe, thermal_warning_flag, shutdown_latched, twf_e, sdl_e;
	logic [2:0]  warn_level, shut_level, high_side_switch, low_side_switch;
	logic [5:0]  drv_e;
	logic [24:0] exp_q[$], exp, seen;
	int          errors, checks_done, cycles, seed;
	tsf_top DUT (.*);
	tsf_spi_master m (.*);
	// ***
	// clock, limit, verdict
	// ***
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 20000) begin
			errors++;
			end_of_test();
		end
	end
	task automatic end_of_test();
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial forever begin
		@(m.done);
		seen = {m.first, m.rx[15:0], high_side_switch, low_side_switch,
			thermal_warning_flag, shutdown_latched};
		exp = exp_q.pop_front();
		checks_done++;
		if (seen !== exp) begin // frame
			errors++;
			$display("ERROR frame expected %h seen %h", exp, seen);
		end
	end
	// ***
	// stimulus
	// ***
	task automatic frame(input int n, input logic [15:0] cmd);
		logic        w;
		logic [15:0] pass;
		w = twf_e;
		pass = 16'($random(seed));
		if (n % 16 == 0) begin
			if (cmd[0] && !warn_level)
				twf_e = 1'b0;
			if (cmd[0] && |cmd[6:1] && !shut_level)
				sdl_e = 1'b0;
			drv_e = cmd[6:1];
		end
		exp_q.push_back({w, n == 32 ? pass : {8'h00, pass[7:0]}, sdl_e ? 6'h00 :
			{drv_e[5], drv_e[3], drv_e[1], drv_e[4], drv_e[2], drv_e[0]}, twf_e, sdl_e});
		@(negedge core_clk);
		m.xfer(n, {pass, cmd});
	endtask
	task automatic sense(input logic [2:0] w, input logic [2:0] s);
		@(negedge core_clk);
		warn_level = w;
		shut_level = s;
		twf_e = twf_e | (|w);
		sdl_e = sdl_e | (|s);
		repeat (10) @(negedge core_clk);
	endtask
	initial begin
		seed = 96391;
		rst = 1'b1;
		clk_en = 1'b1;
		supply_lockout = 1'b0;
		warn_level = 3'h0;
		shut_level = 3'h0;
		twf_e = 1'b0;
		sdl_e = 1'b0;
		drv_e = 6'h00;
		repeat (10) @(negedge core_clk);
		rst = 1'b0;
		repeat (8) @(negedge core_clk);
		for (int i = 0; i < 7; i++)
			frame(32, 16'h0001 << i); // each driver
		sense(3'h1 << ($unsigned($random(seed)) % 3), 3'h0);
		frame(32, 16'h007f); // clear refused while warm
		sense(3'h0, 3'h0);
		frame(32, 16'h0002); // stays latched
		frame(32, 16'h0001); // cleared
		frame(32, 16'h007e);
		sense(3'h0, 3'h1 << ($unsigned($random(seed)) % 3)); // all off
		frame(32, 16'h0054); // on without clear refused
		sense(3'h0, 3'h0);
		frame(32, 16'h0001); // clear without on refused
		frame(32, 16'h002b); // released
		frame(24, 16'($random(seed))); // partial frame dropped
		@(negedge core_clk);
		supply_lockout = 1'b1;
		repeat (20) @(negedge core_clk);
		supply_lockout = 1'b0;
		frame(32, 16'($random(seed))); // after lockout
		repeat (4) @(negedge core_clk);
		end_of_test();
	end
endmodule
